//--- rtl/sdf_formatter.sv
// sd embedded audio packet formatter with axi4-lite control
//
// Summary of operation
// - every packet opens with 000h, 3FFh, 3FFh
// - one identifier word names the packet type
// - optional block counter increments per packet
// - count word precedes user data
// - checksum word follows user data
// - at most 255 user words per packet
// - 23 subframe bits packed into three words
// - audio word bit 9 inverts bit 8
// - block-start bit per channel every 192 frames
// - X+2 bit 8 is even parity
// - X holds block-start, channel, sample bits 0-5
// - X+1 holds sample bits 6-14
// - X+2 holds bits 15-19, V, U, C, parity
// - copy C/U/V, replace subframe parity
// - no packet after switching point line
// - no packet in checkword space
// - three or four samples per channel each
// - 20-bit 48 kHz locked samples
// - four groups of four channels
// - channels always sent in pairs
// - packets only in horizontal blanking space
//
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module sdf_formatter (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire sdf_pkg::sdf_axil_req_t axil_req,
  output      sdf_pkg::sdf_axil_rsp_t axil_rsp,
  input  wire sdf_pkg::sdf_pcm_t     pcm_in,
  output      logic                  pcm_ready,
  input  wire logic                  hanc_open,
  input  wire logic                  switch_line,
  input  wire logic                  edh_space,
  output      sdf_pkg::sdf_anc_t     anc_out,
  input  wire logic                  anc_ready
);
  import sdf_pkg::*;

  function automatic logic [9:0] anc_byte(input logic [7:0] b);
    anc_byte = {~(^b), ^b, b};
  endfunction : anc_byte

  function automatic logic [9:0] sub_word(input sdf_sub_t s, input logic [1:0] ph);
    logic [8:0] x0;
    logic [8:0] x1;
    logic [7:0] x2lo;
    logic [8:0] w;
    x0   = {s.sample[5:0], s.ch[0], s.ch[1], s.z};
    x1   = s.sample[14:6];
    x2lo = {s.c, s.u, s.v, s.sample[19:15]};
    if (ph == 2'h0) begin
      w = x0;
    end else if (ph == 2'h1) begin
      w = x1;
    end else begin
      w = {^{x0, x1, x2lo}, x2lo};
    end
    sub_word = {~w[8], w};
  endfunction : sub_word

  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] d,
                                             input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    apply_strb = r;
  endfunction : apply_strb

  sdf_state_t  state;
  sdf_state_t  next_state;
  sdf_sub_t    mem [MEM_DEPTH];
  logic [31:0] ctrl;
  logic [31:0] pkt_cnt;
  logic [7:0]  dbn;
  logic [7:0]  z_cnt [4];
  logic [4:0]  wr_ptr;
  logic [3:0]  rd_ptr;
  logic [1:0]  ph;
  logic [8:0]  sum;
  sdf_anc_t    out_q;
  logic [1:0]  out_ph;
  logic        bvalid;
  logic [1:0]  bresp;
  logic        rvalid;
  logic [1:0]  rresp;
  logic [31:0] rdata;

  // configuration decode
  wire         en       = ctrl[CTRL_EN_BIT];
  wire         dbn_en   = ctrl[CTRL_DBN_BIT];
  wire         quad     = ctrl[CTRL_QUAD_BIT];
  wire  [1:0]  grp      = ctrl[CTRL_GRP_LSB +: 2];
  wire  [4:0]  spp      = ctrl[CTRL_SPP_BIT] ? SPP_HI : SPP_LO;
  wire  [4:0]  n_sub    = quad ? (spp << 2) : (spp << 1);
  wire  [7:0]  n_udw    = 8'(n_sub) * 8'h03;
  wire  [9:0]  did      = (grp == 2'h0) ? DID_G1 : (grp == 2'h1) ? DID_G2 :
                          (grp == 2'h2) ? DID_G3 : DID_G4;
  wire  [1:0]  in_ch    = quad ? wr_ptr[1:0] : {1'b0, wr_ptr[0]};
  wire         full     = wr_ptr >= n_sub;
  wire         space_ok = hanc_open && !switch_line && !edh_space;
  wire         start    = (state == ST_IDLE) && en && full && space_ok;
  wire         ld       = (state != ST_IDLE) && (!out_q.valid || anc_ready);
  wire         fire     = out_q.valid && anc_ready;
  wire         last_udw = (5'(rd_ptr) == n_sub - 5'h01) && (ph == 2'h2);
  wire         pcm_go   = pcm_in.valid && pcm_ready;

  assign pcm_ready = en && (state == ST_IDLE) && !full;
  assign anc_out   = out_q;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (start) next_state = ST_ADF0;
      ST_ADF0: if (ld) next_state = ST_ADF1;
      ST_ADF1: if (ld) next_state = ST_ADF2;
      ST_ADF2: if (ld) next_state = ST_DID;
      ST_DID:  if (ld) next_state = dbn_en ? ST_DBN : ST_DC;
      ST_DBN:  if (ld) next_state = ST_DC;
      ST_DC:   if (ld) next_state = ST_UDW;
      ST_UDW:  if (ld && last_udw) next_state = ST_CSUM;
      ST_CSUM: if (ld) next_state = ST_IDLE;
    endcase
  end

  logic [9:0] cur_word;
  always_comb begin
    cur_word = ADF_W0;
    unique case (state)
      ST_IDLE: cur_word = ADF_W0;
      ST_ADF0: cur_word = ADF_W0;
      ST_ADF1: cur_word = ADF_W1;
      ST_ADF2: cur_word = ADF_W1;
      ST_DID:  cur_word = did;
      ST_DBN:  cur_word = anc_byte(dbn);
      ST_DC:   cur_word = anc_byte(n_udw);
      ST_UDW:  cur_word = sub_word(mem[rd_ptr], ph);
      ST_CSUM: cur_word = {~sum[8], sum};
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // output word register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_q  <= '0;
      out_ph <= 2'h3;
    end else if (ld) begin
      out_q  <= '{valid: 1'b1, word: cur_word, sop: state == ST_ADF0, eop: state == ST_CSUM};
      out_ph <= (state == ST_UDW) ? ph : 2'h3;
    end else if (fire) begin
      out_q.valid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || (ld && state == ST_ADF0)) begin
      sum <= '0;
    end else if (ld && state inside {ST_DID, ST_DBN, ST_DC, ST_UDW}) begin
      sum <= sum + cur_word[8:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || start) begin
      rd_ptr <= '0;
      ph     <= '0;
    end else if (ld && state == ST_UDW) begin
      ph     <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
      rd_ptr <= (ph == 2'h2) ? rd_ptr + 4'h1 : rd_ptr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dbn     <= DBN_FIRST;
      pkt_cnt <= PCNT_RST;
    end else if (ld && state == ST_CSUM) begin
      pkt_cnt <= pkt_cnt + 32'h1;
      if (dbn_en) begin
        dbn <= (dbn == DBN_LAST) ? DBN_FIRST : dbn + 8'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (pcm_go) begin
      mem[wr_ptr[3:0]] <= '{z: z_cnt[in_ch] == 8'h00, ch: in_ch, c: pcm_in.c,
                            u: pcm_in.u, v: pcm_in.v, sample: pcm_in.sample};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !en || (ld && state == ST_CSUM)) begin
      wr_ptr <= '0;
    end else if (pcm_go) begin
      wr_ptr <= wr_ptr + 5'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      z_cnt <= '{default: 8'h00};
    end else if (pcm_go) begin
      z_cnt[in_ch] <= (z_cnt[in_ch] == Z_LAST) ? 8'h00 : z_cnt[in_ch] + 8'h01;
    end
  end

  // axi4-lite slave
  wire        wr_go    = axil_req.awvalid && axil_req.wvalid && !bvalid;
  wire        rd_go    = axil_req.arvalid && !rvalid;
  wire        wr_ctrl  = axil_req.awaddr == CTRL_OFS;
  wire        wr_map   = wr_ctrl || axil_req.awaddr inside {STAT_OFS, DBN_OFS, PCNT_OFS};
  wire [31:0] status   = {26'h0, (state != ST_IDLE), wr_ptr};
  wire        rd_map   = axil_req.araddr inside {CTRL_OFS, STAT_OFS, DBN_OFS, PCNT_OFS};
  wire [31:0] rd_mux   = (axil_req.araddr == CTRL_OFS) ? ctrl :
                         (axil_req.araddr == STAT_OFS) ? status :
                         (axil_req.araddr == DBN_OFS)  ? {24'h0, dbn} :
                         (axil_req.araddr == PCNT_OFS) ? pkt_cnt : 32'h0;

  assign axil_rsp = '{awready: wr_go, wready: wr_go, bresp: bresp, bvalid: bvalid,
                      arready: !rvalid, rdata: rdata, rresp: rresp, rvalid: rvalid};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl   <= CTRL_RST;
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
      if (wr_ctrl) begin
        ctrl <= apply_strb(ctrl, axil_req.wdata, axil_req.wstrb);
      end
    end else if (axil_req.bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rresp  <= RESP_OKAY;
      rdata  <= 32'h0;
    end else if (rd_go) begin
      rvalid <= 1'b1;
      rresp  <= rd_map ? RESP_OKAY : RESP_SLVERR;
      rdata  <= rd_mux;
    end else if (axil_req.rready) begin
      rvalid <= 1'b0;
    end
  end

  // checking helpers
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [7:0] h_idx;
  logic [8:0] h_sum;
  logic [8:0] h_x0;
  logic [8:0] h_x1;
  logic [7:0] h_udw;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      h_idx <= '0;
      h_sum <= '0;
      h_x0  <= '0;
      h_x1  <= '0;
      h_udw <= '0;
    end else if (fire) begin
      h_idx <= out_q.eop ? 8'h00 : h_idx + 8'h01;
      h_sum <= (out_q.eop || h_idx < 8'h03) ? 9'h000 : h_sum + out_q.word[8:0];
      h_udw <= out_q.eop ? 8'h00 : (out_ph != 2'h3) ? h_udw + 8'h01 : h_udw;
      if (out_ph == 2'h0) h_x0 <= out_q.word[8:0];
      if (out_ph == 2'h1) h_x1 <= out_q.word[8:0];
    end
  end

  a_flag_header: assert property (fire && h_idx == 8'h00 |-> out_q.word == ADF_W0 && out_q.sop
                                  ##1 (!fire || out_q.word == ADF_W1)[*2])
    else $error("flag header wrong");
  a_ident_word: assert property (fire && h_idx == 8'h03 |-> out_q.word == did)
    else $error("identifier word wrong");
  a_block_count: assert property (ld && state == ST_CSUM && dbn_en
                                  |=> dbn == (($past(dbn) == DBN_LAST) ? DBN_FIRST
                                              : $past(dbn) + 8'h01))
    else $error("block counter did not step");
  a_count_word: assert property (fire && out_q.eop |-> h_udw == n_udw)
    else $error("count and user words disagree");
  a_check_sum: assert property (fire && out_q.eop
                                |-> out_q.word == {~h_sum[8], h_sum})
    else $error("checksum mismatch");
  a_inv_bit: assert property (fire && h_idx >= 8'h03 |-> out_q.word[9] != out_q.word[8])
    else $error("bit 9 not inverse of bit 8");
  a_even_parity: assert property (fire && out_ph == 2'h2
                                  |-> ^{h_x0, h_x1, out_q.word[8:0]} == 1'b0)
    else $error("parity odd");
  a_placement_ok: assert property (state == ST_IDLE ##1 state == ST_ADF0
                                   |-> $past(space_ok))
    else $error("packet started outside window");
  a_udw_limit: assert property (fire |-> h_udw <= n_udw && n_udw <= UDW_MAX)
    else $error("user word count out of range");
  a_sop_order: assert property (ld && state == ST_ADF0 |=> out_q.valid && out_q.sop)
    else $error("start of packet not marked");

  c_packet_done: cover property (fire && out_q.eop);
  c_with_dbn: cover property (fire && h_idx == 8'h04 && dbn_en);
  c_stall: cover property (out_q.valid && !anc_ready ##1 fire);
  c_quad_pkt: cover property (fire && out_q.eop && quad);
endmodule : sdf_formatter

//--- rtl/sdf_pkg.sv
// constants, types and register map of the sd audio packet formatter
package sdf_pkg;
  localparam logic [9:0]  ADF_W0       = 10'h000;
  localparam logic [9:0]  ADF_W1       = 10'h3FF;
  localparam logic [9:0]  DID_G1       = 10'h2FF;
  localparam logic [9:0]  DID_G2       = 10'h1FD;
  localparam logic [9:0]  DID_G3       = 10'h1FB;
  localparam logic [9:0]  DID_G4       = 10'h2F9;
  localparam logic [7:0]  DBN_FIRST    = 8'h01;
  localparam logic [7:0]  DBN_LAST     = 8'hFF;
  localparam logic [7:0]  Z_LAST       = 8'hBF;
  localparam logic [7:0]  UDW_MAX      = 8'hFF;
  localparam logic [4:0]  SPP_LO       = 5'h03;
  localparam logic [4:0]  SPP_HI       = 5'h04;
  localparam int          MEM_DEPTH    = 16;
  localparam logic [7:0]  CTRL_OFS     = 8'h00;
  localparam logic [7:0]  STAT_OFS     = 8'h04;
  localparam logic [7:0]  DBN_OFS      = 8'h08;
  localparam logic [7:0]  PCNT_OFS     = 8'h0C;
  localparam int          CTRL_EN_BIT  = 0;
  localparam int          CTRL_DBN_BIT = 1;
  localparam int          CTRL_QUAD_BIT = 2;
  localparam int          CTRL_GRP_LSB = 3;
  localparam int          CTRL_SPP_BIT = 5;
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
  localparam logic [31:0] PCNT_RST     = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } sdf_axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } sdf_axil_rsp_t;

  typedef struct packed {
    logic        valid;
    logic [19:0] sample;
    logic        c;
    logic        u;
    logic        v;
  } sdf_pcm_t;

  typedef struct packed {
    logic        z;
    logic [1:0]  ch;
    logic        c;
    logic        u;
    logic        v;
    logic [19:0] sample;
  } sdf_sub_t;

  typedef struct packed {
    logic        valid;
    logic [9:0]  word;
    logic        sop;
    logic        eop;
  } sdf_anc_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADF0, ST_ADF1, ST_ADF2, ST_DID, ST_DBN, ST_DC, ST_UDW, ST_CSUM
  } sdf_state_t;
endpackage : sdf_pkg

//--- testbench/sdf_anc_sink.sv
// ancillary word sink standing in for the video multiplexer
`timescale 1ns/1ps
module sdf_anc_sink (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire sdf_pkg::sdf_anc_t anc,
  input  wire logic              slow,
  output      logic              anc_ready,
  output      logic              csum_err
);
  import sdf_pkg::*;
  logic [11:0] got[$];
  logic [8:0]  acc;
  logic [1:0]  pace;
  int          idx;
  // slow mode takes one word in four
  assign anc_ready = !slow || (pace == 2'h0);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pace <= 2'h0;
      acc <= 9'h000;
      idx <= 0;
      csum_err <= 1'b0;
    end else begin
      pace <= pace + 2'h1;
      if (anc.valid && anc_ready) begin
        got.push_back({anc.sop, anc.eop, anc.word});
        idx <= anc.sop ? 1 : idx + 1;
        if (anc.sop) begin
          acc <= 9'h000;
        end else if (idx >= 3 && !anc.eop) begin
          acc <= acc + anc.word[8:0];
        end
        if (anc.eop) begin
          csum_err <= csum_err | (anc.word[8:0] != acc);
        end
      end
    end
  end
endmodule : sdf_anc_sink

//--- testbench/testbench.sv
// self-checking bench for the sd audio packet formatter
`timescale 1ns/1ps
module testbench;
  import sdf_pkg::*;
  logic          aclk;
  logic          aresetn;
  sdf_axil_req_t req;
  sdf_axil_rsp_t rsp;
  sdf_pcm_t      pcm;
  logic          pcm_ready;
  logic          hanc_open;
  logic          switch_line;
  logic          edh_space;
  sdf_anc_t      anc;
  logic          anc_ready;
  logic          slow;
  logic          csum_err;
  int            fail_count;
  int            samples_checked;
  int            fcnt[4];
  int            seq;
  logic [31:0]   rd;
  logic [1:0]    rr;
  logic [1:0]    br;
  logic [11:0]   exp_q[$];
  logic [9:0]    uq[$];
  localparam logic [9:0] DIDS[4] = '{DID_G1, DID_G2, DID_G3, DID_G4};

  sdf_formatter DUT (.aclk(aclk), .aresetn(aresetn), .axil_req(req), .axil_rsp(rsp),
    .pcm_in(pcm), .pcm_ready(pcm_ready), .hanc_open(hanc_open), .switch_line(switch_line),
    .edh_space(edh_space), .anc_out(anc), .anc_ready(anc_ready));
  sdf_anc_sink sink (.aclk(aclk), .aresetn(aresetn), .anc(anc), .slow(slow),
    .anc_ready(anc_ready), .csum_err(csum_err));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic give_verdict;
    $display("mismatches %0d, checks %0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic hang;
    fail_count++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    give_verdict();
  endtask : hang

  function automatic logic [9:0] w(input logic [8:0] b);
    return {~b[8], b};
  endfunction : w

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    for (i = 0; i < 50 && !(rsp.awready && rsp.wready); i++) @(posedge aclk);
    if (i == 50) hang();
    req.awvalid <= 1'b0;
    req.wvalid <= 1'b0;
    for (i = 0; i < 50 && !rsp.bvalid; i++) @(posedge aclk);
    if (i == 50) hang();
    br = rsp.bresp;
    req.bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    int i;
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    @(posedge aclk);
    for (i = 0; i < 50 && !rsp.arready; i++) @(posedge aclk);
    if (i == 50) hang();
    req.arvalid <= 1'b0;
    for (i = 0; i < 50 && !rsp.rvalid; i++) @(posedge aclk);
    if (i == 50) hang();
    rd = rsp.rdata;
    rr = rsp.rresp;
    req.rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_rd

  task automatic feed(input int nch, input int n);
    int k;
    int i;
    logic [1:0]  ch;
    logic [19:0] s;
    logic        z;
    logic [8:0]  x0;
    logic [7:0]  x2;
    for (k = 0; k < n; k++) begin
      ch = 2'(k % nch);
      s = 20'(seq * 32'h0002_F1D3 + 32'h0005_A3C1);
      z = (fcnt[ch] % 192) == 0;
      fcnt[ch]++;
      pcm <= '{1'b1, s, seq[0], seq[1], seq[2]};
      @(posedge aclk);
      for (i = 0; i < 100 && !pcm_ready; i++) @(posedge aclk);
      if (i == 100) hang();
      x0 = {s[5:0], ch[0], ch[1], z};
      x2 = {seq[0], seq[1], seq[2], s[19:15]};
      uq.push_back(w(x0));
      uq.push_back(w(s[14:6]));
      uq.push_back(w({^{x0, s[14:6], x2}, x2}));
      seq++;
    end
    pcm.valid <= 1'b0;
  endtask : feed

  task automatic packet(input logic [31:0] ctrl, input logic [7:0] dbn);
    int i;
    int nch;
    int n;
    logic [8:0] cs;
    logic [9:0] wd;
    nch = ctrl[CTRL_QUAD_BIT] ? 4 : 2;
    n = nch * (ctrl[CTRL_SPP_BIT] ? 4 : 3);
    feed(nch, n);
    #1;
    check(pcm_ready, 1'b0);
    @(posedge aclk);
    axi_rd(STAT_OFS);
    check(rd, 32'(n));
    hanc_open <= 1'b1;
    switch_line <= 1'b1;
    repeat (6) @(posedge aclk);
    switch_line <= 1'b0;
    edh_space <= 1'b1;
    repeat (6) @(posedge aclk);
    check(sink.got.size(), 0);
    edh_space <= 1'b0;
    for (i = 0; i < 2000 && !(sink.got.size() > 0 && sink.got[$][10]); i++) @(posedge aclk);
    if (i == 2000) hang();
    hanc_open <= 1'b0;
    exp_q = '{{2'b10, ADF_W0}, {2'b00, ADF_W1}, {2'b00, ADF_W1}};
    wd = DIDS[ctrl[CTRL_GRP_LSB +: 2]];
    exp_q.push_back({2'b00, wd});
    cs = wd[8:0];
    if (ctrl[CTRL_DBN_BIT]) begin
      wd = w({^dbn, dbn});
      exp_q.push_back({2'b00, wd});
      cs += wd[8:0];
    end
    wd = w({^(8'(uq.size())), 8'(uq.size())});
    uq.push_front(wd);
    foreach (uq[k]) begin
      exp_q.push_back({2'b00, uq[k]});
      cs += uq[k][8:0];
    end
    exp_q.push_back({2'b01, w(cs)});
    check(sink.got.size(), exp_q.size());
    for (i = 0; i < exp_q.size() && i < sink.got.size(); i++) begin
      check(sink.got[i], exp_q[i]);
    end
    check(csum_err, 1'b0);
    sink.got.delete();
    uq.delete();
  endtask : packet

  task automatic run_cfg(input logic [31:0] ctrl, input int npk);
    int p;
    logic [7:0] dbn;
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    fcnt = '{0, 0, 0, 0};
    axi_rd(CTRL_OFS);
    check(rd, CTRL_RST);
    check(rr, RESP_OKAY);
    axi_rd(DBN_OFS);
    check(rd, 32'(DBN_FIRST));
    axi_wr(CTRL_OFS, ctrl);
    check(br, RESP_OKAY);
    axi_rd(CTRL_OFS);
    check(rd, ctrl);
    dbn = DBN_FIRST;
    for (p = 0; p < npk; p++) begin
      slow <= p[0];
      packet(ctrl, dbn);
      if (ctrl[CTRL_DBN_BIT]) dbn = (dbn == DBN_LAST) ? DBN_FIRST : dbn + 8'h01;
    end
    axi_wr(PCNT_OFS, 32'hFFFF_FFFF);
    check(br, RESP_OKAY);
    axi_rd(PCNT_OFS);
    check(rd, 32'(npk));
    axi_rd(DBN_OFS);
    check(rd, 32'(dbn));
    axi_wr(8'h10, 32'hFFFF_FFFF);
    check(br, RESP_SLVERR);
    axi_rd(8'h10);
    check(rd, 32'h0000_0000);
    check(rr, RESP_SLVERR);
  endtask : run_cfg

  initial begin
    req = '0;
    pcm = '0;
    hanc_open = 1'b0;
    switch_line = 1'b0;
    edh_space = 1'b0;
    slow = 1'b0;
    aresetn = 1'b0;
    fail_count = 0;
    samples_checked = 0;
    seq = 0;
    run_cfg(32'h0000_0003, 256);
    run_cfg(32'h0000_002D, 1);
    run_cfg(32'h0000_0033, 2);
    run_cfg(32'h0000_001D, 1);
    give_verdict();
  end
endmodule : testbench
